// ### secp_command_protect.sv
// serial eeprom front end: op-code decode, status byte and write protection
`timescale 1ns/1ps
module secp_command_protect #(
  parameter int WRITE_CYCLES = secp_pkg::WRITE_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        si_in,
  input  wire logic        hold_n_in,
  input  wire logic        wp_n_in,
  output logic             so_out,
  output logic             so_oe_out,
  output logic             busy_out,
  output logic             array_write_start_out,
  output logic      [15:0] array_write_addr_out,
  output logic      [7:0]  array_write_data_out
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);

  // ---------------- link side, clocked by the master's clock ----------------
  logic                    link_rst;
  logic                    paused_reg;
  logic [5:0]              cnt_reg;
  logic [15:0]             shift_reg;
  logic [7:0]              shift_in;
  secp_pkg::secp_kind_type kind_reg;
  logic [7:0]              sdata_reg;
  logic                    sdone_reg;
  logic [15:0]             addr_reg;
  logic [7:0]              wdata_reg;
  logic                    wdone_reg;
  logic                    so_reg;
  logic                    so_oe_reg;
  logic [7:0]              snap_reg;

  // deselect clears the sequence at once, without a clock edge
  assign link_rst = rst_in | cs_n_in;
  assign shift_in = {shift_reg[6:0], si_in};

  function automatic secp_pkg::secp_kind_type op_kind(input logic [7:0] op);
    logic [7:0] m;
    m = op & secp_pkg::OP_MASK;
    case (m)
      secp_pkg::OP_SET_WEL: op_kind = secp_pkg::KIND_SETWEL;
      secp_pkg::OP_CLR_WEL: op_kind = secp_pkg::KIND_CLRWEL;
      secp_pkg::OP_STAT_RD: op_kind = secp_pkg::KIND_STATRD;
      secp_pkg::OP_STAT_WR: op_kind = secp_pkg::KIND_STATWR;
      secp_pkg::OP_ARR_RD:  op_kind = secp_pkg::KIND_ARRRD;
      secp_pkg::OP_ARR_WR:  op_kind = secp_pkg::KIND_ARRWR;
      default:              op_kind = secp_pkg::KIND_BAD;
    endcase
  endfunction

  // the master only moves the pause pin with the clock low, so the
  // rising edge sees it settled and no synchroniser is needed here
  always_ff @(posedge sck_in or posedge link_rst) begin
    if (link_rst) begin
      paused_reg <= 1'b0;
    end else begin
      paused_reg <= ~hold_n_in;
    end
  end

  always_ff @(posedge sck_in or posedge link_rst) begin
    if (link_rst) begin
      cnt_reg   <= 6'h00;
      shift_reg <= 16'h0000;
    end else if (hold_n_in && kind_ok(cnt_reg, kind_reg)) begin
      shift_reg <= {shift_reg[14:0], si_in};
      if (cnt_reg != secp_pkg::CNT_MAX) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  // after a bad op-code nothing further is shifted in
  function automatic logic kind_ok(input logic [5:0] c, input secp_pkg::secp_kind_type k);
    kind_ok = (c <= secp_pkg::CNT_OP_LAST) || (k != secp_pkg::KIND_BAD);
  endfunction

  // captured words are not cleared by deselect: the core reads them
  // after chip select rises, and they hold until the next frame
  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      kind_reg  <= secp_pkg::KIND_NONE;
      sdata_reg <= 8'h00;
      sdone_reg <= 1'b0;
      addr_reg  <= 16'h0000;
      wdata_reg <= 8'h00;
      wdone_reg <= 1'b0;
    end else if (!cs_n_in && hold_n_in) begin
      if (cnt_reg == 6'h00) begin
        kind_reg  <= secp_pkg::KIND_NONE;
        sdone_reg <= 1'b0;
        wdone_reg <= 1'b0;
      end
      if (cnt_reg == secp_pkg::CNT_OP_LAST) begin
        kind_reg <= op_kind(shift_in);
      end
      if (cnt_reg == secp_pkg::CNT_SDATA_LAST && kind_reg == secp_pkg::KIND_STATWR) begin
        sdata_reg <= shift_in;
        sdone_reg <= 1'b1;
      end
      if (cnt_reg == secp_pkg::CNT_ADDR_LAST && kind_reg == secp_pkg::KIND_ARRWR) begin
        addr_reg <= {shift_reg[14:0], si_in};
      end
      if (cnt_reg == secp_pkg::CNT_WDATA_LAST && kind_reg == secp_pkg::KIND_ARRWR) begin
        wdata_reg <= shift_in;
        wdone_reg <= 1'b1;
      end
    end
  end

  // output changes on the falling edge, msb of the status byte first
  always_ff @(negedge sck_in or posedge link_rst) begin
    if (link_rst) begin
      so_oe_reg <= 1'b0;
      so_reg    <= 1'b0;
    end else begin
      so_oe_reg <= kind_reg == secp_pkg::KIND_STATRD
                   && cnt_reg >= secp_pkg::CNT_DATA_FIRST;
      so_reg    <= snap_reg[~cnt_reg[2:0]];
    end
  end

  assign so_out    = so_reg;
  // pause gates the pin directly, so the held bit returns as hold lifts
  assign so_oe_out = so_oe_reg && hold_n_in;

  // ---------------- core side, clocked by clock_in ----------------
  logic                     cs_q;
  logic                     wp_q;
  logic                     cs_prev_reg;
  logic                     wp_prev_reg;
  logic                     wp_fell_reg;
  logic                     cs_rise;
  logic                     idle_rise;
  logic                     hw_prot;
  logic                     sr_go;
  logic                     arr_go;
  logic                     cyc_end;
  secp_pkg::secp_state_type state_reg;
  logic [TW-1:0]            timer_reg;
  logic                     pend_sr_reg;
  logic [7:0]               pend_data_reg;
  logic                     wel_reg;
  logic                     protect_enable_bit_reg;
  logic [1:0]               bp_reg;
  logic                     arr_start_reg;
  logic [15:0]              arr_addr_reg;
  logic [7:0]               arr_data_reg;

  secp_sync #(
    .WIDTH   (2),
    .RST_VAL (secp_pkg::PIN_SYNC_RST)
  ) u_pin_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     ({cs_n_in, wp_n_in}),
    .q_out    ({cs_q, wp_q})
  );

  function automatic logic block_hit(input logic [15:0] a, input logic [1:0] bp);
    case (bp)
      2'h0:    block_hit = 1'b0;
      2'h1:    block_hit = a >= secp_pkg::BP_QUARTER_BASE;
      2'h2:    block_hit = a >= secp_pkg::BP_HALF_BASE;
      default: block_hit = 1'b1;
    endcase
  endfunction

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cs_prev_reg <= 1'b1;
      wp_prev_reg <= 1'b1;
      wp_fell_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_q;
      wp_prev_reg <= wp_q;
      // a fall in the same cycle as frame start still counts
      if (!cs_q && wp_prev_reg && !wp_q) begin
        wp_fell_reg <= 1'b1;
      end else if (!cs_q && cs_prev_reg) begin
        wp_fell_reg <= 1'b0;
      end
    end
  end

  assign cs_rise   = cs_q && !cs_prev_reg;
  assign idle_rise = cs_rise && state_reg == secp_pkg::ST_IDLE;
  assign hw_prot   = protect_enable_bit_reg && !wp_q;
  assign sr_go     = idle_rise && kind_reg == secp_pkg::KIND_STATWR && sdone_reg && wel_reg
                     && !hw_prot && !(protect_enable_bit_reg && wp_fell_reg);
  assign arr_go    = idle_rise && kind_reg == secp_pkg::KIND_ARRWR && wdone_reg && wel_reg
                     && !block_hit(addr_reg, bp_reg);
  assign cyc_end   = state_reg == secp_pkg::ST_WRITING && timer_reg == TW'(WRITE_CYCLES - 1);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg     <= secp_pkg::ST_IDLE;
      timer_reg     <= '0;
      pend_sr_reg   <= 1'b0;
      pend_data_reg <= 8'h00;
    end else begin
      case (state_reg)
        secp_pkg::ST_IDLE: begin
          timer_reg <= '0;
          if (sr_go || arr_go) begin
            state_reg     <= secp_pkg::ST_WRITING;
            pend_sr_reg   <= sr_go;
            pend_data_reg <= sdata_reg;
          end
        end
        secp_pkg::ST_WRITING: begin
          timer_reg <= timer_reg + TW'(1);
          if (cyc_end) begin
            state_reg <= secp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= secp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // nonvolatile bits change only when the self-timed cycle completes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      protect_enable_bit_reg <= secp_pkg::PROTECT_ENABLE_BIT_RST;
      bp_reg   <= secp_pkg::BP_RST;
    end else if (cyc_end && pend_sr_reg) begin
      protect_enable_bit_reg <= pend_data_reg[secp_pkg::ST_PROTECT_ENABLE_BIT_BIT];
      bp_reg   <= pend_data_reg[secp_pkg::ST_BPH_BIT:secp_pkg::ST_BPL_BIT];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wel_reg <= 1'b0;
    end else if (cyc_end) begin
      wel_reg <= 1'b0;
    end else if (idle_rise && kind_reg == secp_pkg::KIND_SETWEL) begin
      wel_reg <= 1'b1;
    end else if (idle_rise && kind_reg == secp_pkg::KIND_CLRWEL) begin
      wel_reg <= 1'b0;
    end
  end

  // only the first data byte is handed on; page bursts are not kept
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      arr_start_reg <= 1'b0;
      arr_addr_reg  <= 16'h0000;
      arr_data_reg  <= 8'h00;
    end else begin
      arr_start_reg <= arr_go;
      if (arr_go) begin
        arr_addr_reg <= addr_reg;
        arr_data_reg <= wdata_reg;
      end
    end
  end

  // frozen while selected, so the link reads a stable word; a busy
  // end inside a status-read frame shows on the next frame only
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      snap_reg <= 8'h00;
    end else if (cs_q) begin
      if (state_reg == secp_pkg::ST_WRITING) begin
        snap_reg <= secp_pkg::ST_BUSY_VIEW;
      end else begin
        snap_reg <= {protect_enable_bit_reg, 3'h0, bp_reg, wel_reg, 1'b0};
      end
    end
  end

  assign busy_out              = state_reg == secp_pkg::ST_WRITING;
  assign array_write_start_out = arr_start_reg;
  assign array_write_addr_out  = arr_addr_reg;
  assign array_write_data_out  = arr_data_reg;

  // ---------------- checks ----------------
  a_wel_set_cmd: assert property (@(posedge clock_in) disable iff (rst_in)
    idle_rise && kind_reg == secp_pkg::KIND_SETWEL |=> wel_reg)
    else $error("set-latch command did not set the latch");
  a_wel_clear_cmd: assert property (@(posedge clock_in) disable iff (rst_in)
    idle_rise && kind_reg == secp_pkg::KIND_CLRWEL |=> !wel_reg && !busy_out)
    else $error("clear-latch command left latch set");
  a_cycle_end_wel: assert property (@(posedge clock_in) disable iff (rst_in)
    cyc_end |=> !wel_reg && state_reg == secp_pkg::ST_IDLE)
    else $error("write cycle end did not clear latch");
  a_busy_ignores: assert property (@(posedge clock_in) disable iff (rst_in)
    state_reg == secp_pkg::ST_WRITING && !cyc_end |=> $stable(wel_reg) && $stable(bp_reg))
    else $error("command acted during write cycle");
  a_guard_refuse: assert property (@(posedge clock_in) disable iff (rst_in)
    idle_rise && kind_reg == secp_pkg::KIND_STATWR && hw_prot
    |=> state_reg == secp_pkg::ST_IDLE)
    else $error("status write accepted under hardware protection");
  a_guard_ignored: assert property (@(posedge clock_in) disable iff (rst_in)
    idle_rise && kind_reg == secp_pkg::KIND_STATWR && sdone_reg && wel_reg && !protect_enable_bit_reg
    |=> state_reg == secp_pkg::ST_WRITING)
    else $error("status write refused with protect-enable clear");
  a_guard_abort: assert property (@(posedge clock_in) disable iff (rst_in)
    idle_rise && protect_enable_bit_reg && wp_fell_reg |=> !(state_reg == secp_pkg::ST_WRITING && pend_sr_reg))
    else $error("status write not aborted by guard fall");
  a_cycle_holds: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(busy_out) |-> busy_out [*8])
    else $error("write cycle ended too early");
  a_view_busy: assert property (@(posedge clock_in) disable iff (rst_in)
    cs_q && busy_out |=> snap_reg == secp_pkg::ST_BUSY_VIEW)
    else $error("status view not all ones while busy");
  a_view_idle: assert property (@(posedge clock_in) disable iff (rst_in)
    cs_q && !busy_out |=> snap_reg[6:4] == 3'h0 && !snap_reg[0] && snap_reg[1] == $past(wel_reg))
    else $error("idle status view wrong");
  a_block_array: assert property (@(posedge clock_in) disable iff (rst_in)
    idle_rise && kind_reg == secp_pkg::KIND_ARRWR && block_hit(addr_reg, bp_reg)
    |=> !array_write_start_out ##1 !array_write_start_out)
    else $error("array write started in protected block");
  a_so_deselect: assert property (@(posedge clock_in) disable iff (rst_in)
    cs_n_in |-> !so_oe_reg)
    else $error("output driven while deselected");
  a_pause_quiet: assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
    paused_reg |-> !so_oe_out)
    else $error("output driven while paused");
  a_pause_frozen: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
    !hold_n_in |=> $stable(cnt_reg) && $stable(shift_reg))
    else $error("sequence moved while paused");
  a_bad_op_quiet: assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
    kind_reg == secp_pkg::KIND_BAD |=> !so_oe_reg)
    else $error("output driven after bad op-code");

  c_status_write: cover property (@(posedge clock_in) disable iff (rst_in) sr_go);
  c_array_write: cover property (@(posedge clock_in) disable iff (rst_in) arr_go);
  c_status_read: cover property (@(negedge sck_in) disable iff (rst_in) so_oe_reg);
  c_pause: cover property (@(posedge sck_in) disable iff (rst_in) paused_reg ##1 !paused_reg);
endmodule

// ### secp_pkg.sv
// constants and types for the serial eeprom command and protection front end
package secp_pkg;
  // op-codes, bit 3 masked off before compare
  localparam logic [7:0] OP_MASK      = 8'hf7;
  localparam logic [7:0] OP_SET_WEL   = 8'h06;
  localparam logic [7:0] OP_CLR_WEL   = 8'h04;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_ARR_RD    = 8'h03;
  localparam logic [7:0] OP_ARR_WR    = 8'h02;
  // status byte layout
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_WEL_BIT   = 1;
  localparam int         ST_BPL_BIT   = 2;
  localparam int         ST_BPH_BIT   = 3;
  localparam int         ST_PROTECT_ENABLE_BIT_BIT  = 7;
  localparam logic [7:0] ST_BUSY_VIEW = 8'hff;
  // reset values of the nonvolatile bits and of the pin synchroniser
  localparam logic       PROTECT_ENABLE_BIT_RST     = 1'b0;
  localparam logic [1:0] BP_RST       = 2'h0;
  localparam logic [1:0] PIN_SYNC_RST = 2'h3;
  // protected region bases per block-protect level
  localparam logic [15:0] BP_QUARTER_BASE = 16'hc000;
  localparam logic [15:0] BP_HALF_BASE    = 16'h8000;
  // received-bit counter values (count of rising edges before the edge)
  localparam logic [5:0] CNT_OP_LAST    = 6'h07;
  localparam logic [5:0] CNT_SDATA_LAST = 6'h0f;
  localparam logic [5:0] CNT_ADDR_LAST  = 6'h17;
  localparam logic [5:0] CNT_WDATA_LAST = 6'h1f;
  localparam logic [5:0] CNT_MAX        = 6'h20;
  localparam logic [5:0] CNT_DATA_FIRST = 6'h08;
  // timing
  localparam int CLK_HZ        = 20000000;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    KIND_NONE   = 3'b000,
    KIND_SETWEL = 3'b001,
    KIND_CLRWEL = 3'b010,
    KIND_STATRD = 3'b011,
    KIND_STATWR = 3'b100,
    KIND_ARRRD  = 3'b101,
    KIND_ARRWR  = 3'b110,
    KIND_BAD    = 3'b111
  } secp_kind_type;

  typedef enum logic {
    ST_IDLE    = 1'b0,
    ST_WRITING = 1'b1
  } secp_state_type;
endpackage

// ### secp_sync.sv
// pin synchroniser: three sampling flops and an output flop, output moves when second and third agree
`timescale 1ns/1ps
module secp_sync #(
  parameter int               WIDTH   = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          s1_reg <= RST_VAL[i];
          s2_reg <= RST_VAL[i];
          s3_reg <= RST_VAL[i];
          q_reg  <= RST_VAL[i];
        end else begin
          s1_reg <= d_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // a single disagreeing sample is treated as a glitch
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign q_out[i] = q_reg;
    end
  endgenerate
endmodule

// ### secp_spi_master.sv
// spi mode 0 master model for the serial link of the eeprom front end
`timescale 1ns/1ps
module secp_spi_master (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      hold_n_out,
  output logic      wp_n_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  localparam realtime HALF = 62.5;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hold_n_out = 1'b1;
    wp_n_out = 1'b1;
  end
  // clock only runs inside a frame; rx keeps the last eight bits seen on so
  task automatic frame(input int nbits, input logic [31:0] tx, input int hold_at,
                       input int wp_at, output logic [7:0] rx, output logic oe_any);
    int i;
    rx = 8'h00;
    oe_any = 1'b0;
    cs_n_out = 1'b0;
    #HALF;
    for (i = nbits - 1; i >= 0; i--) begin
      if (nbits - 1 - i == hold_at) begin
        hold_n_out = 1'b0;
        repeat (2) begin
          si_out = ~tx[i];
          #HALF;
          sck_out = 1'b1;
          #HALF;
          sck_out = 1'b0;
        end
        hold_n_out = 1'b1;
      end
      if (nbits - 1 - i == wp_at) wp_n_out = 1'b0;
      // guard pulse ends inside the frame, so only the fall itself can abort
      if (wp_at >= 0 && nbits - 1 - i == wp_at + 4) wp_n_out = 1'b1;
      si_out = tx[i];
      #HALF;
      // a released so line reads as the inverse of its last bit
      rx = {rx[6:0], so_oe_in ? so_in : ~rx[0]};
      oe_any = oe_any | so_oe_in;
      sck_out = 1'b1;
      #HALF;
      sck_out = 1'b0;
    end
    #HALF;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #400;
  endtask
endmodule

// ### secp_command_protect_tb.sv
// self-checking bench for the eeprom command and protection front end
`timescale 1ns/1ps
`define CHK(what, e_val, g_val) \
  begin \
    samples_checked++; \
    if ((g_val) !== (e_val)) begin \
      n_mismatch++; \
      $display("ERROR %s expected %h seen %h", what, e_val, g_val); \
    end \
  end
module secp_command_protect_tb;
  // long enough that a status read fits inside one write cycle
  localparam int WCYC = 200;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sck, cs_n, si, hold_n, wp_n, so, so_oe, busy, wstart;
  logic [15:0] waddr;
  logic [15:0] last_addr = 16'h0000;
  logic [7:0]  wdata;
  logic [7:0]  last_data = 8'h00;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          busy_len = 0;
  int          n_start = 0;

  secp_command_protect #(.WRITE_CYCLES(WCYC)) secp_command_protect_inst (
    .clock_in(clk), .rst_in(rst), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .hold_n_in(hold_n), .wp_n_in(wp_n), .so_out(so), .so_oe_out(so_oe),
    .busy_out(busy), .array_write_start_out(wstart),
    .array_write_addr_out(waddr), .array_write_data_out(wdata));
  secp_spi_master secp_spi_master_inst (
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
    .wp_n_out(wp_n), .so_in(so), .so_oe_in(so_oe));

  initial begin
    forever #25 clk = ~clk;
  end
  // counts only grow, so scenarios judge by differences
  always @(posedge clk) begin
    if (busy === 1'b1) busy_len <= busy_len + 1;
    if (wstart === 1'b1) begin
      n_start <= n_start + 1;
      last_addr <= waddr;
      last_data <= wdata;
    end
  end

  task automatic send(input int nbits, input logic [31:0] tx, output logic [7:0] rx);
    logic oe;
    secp_spi_master_inst.frame(nbits, tx, -1, -1, rx, oe);
  endtask
  task automatic rd_status(input logic [7:0] op, output logic [7:0] st);
    send(16, {16'h0000, op, 8'h00}, st);
  endtask
  // latch set, then the write frame; a refused write leaves busy low
  task automatic do_write(input int nbits, input logic [31:0] tx, input int wp_at,
                          input logic ok);
    int b0, s0, k;
    logic [7:0] r;
    logic oe;
    send(8, 32'h06, r);
    b0 = busy_len;
    s0 = n_start;
    secp_spi_master_inst.frame(nbits, tx, -1, wp_at, r, oe);
    for (k = 0; k < WCYC + 40 && busy !== 1'b0; k++) @(posedge clk);
    @(posedge clk);
    `CHK("busy cycles", ok ? WCYC : 0, busy_len - b0)
    if (nbits == 32) begin
      `CHK("array starts", ok ? 1 : 0, n_start - s0)
      if (ok) `CHK("array addr data", tx[23:0], {last_addr, last_data})
    end
    if (ok) begin
      rd_status(8'h05, r);
      `CHK("latch and busy after write", 2'b00, r[1:0])
    end
    else send(8, 32'h04, r);
  endtask

  task automatic t_power_up;
    logic [7:0] r;
    logic oe;
    `CHK("so enable idle", 1'b0, so_oe)
    rd_status(8'h05, r);
    `CHK("status after power up", 8'h00, r)
    secp_spi_master_inst.frame(8, 32'h05, -1, -1, r, oe);
    `CHK("so enable in op-code", 1'b0, oe)
  endtask
  task automatic t_decode;
    logic [7:0] r;
    logic oe;
    logic [7:0] ops [2] = '{8'h06, 8'h0e};
    foreach (ops[i]) begin
      send(8, {24'h0, ops[i]}, r);
      rd_status(8'h0d, r);
      `CHK("latch set", 8'h02, r)
      send(8, {24'h0, ops[i] ^ 8'h0a}, r);
      rd_status(8'h05, r);
      `CHK("latch clear", 8'h00, r)
    end
    send(8, 32'h06, r);
    secp_spi_master_inst.frame(16, 32'h0500, 4, -1, r, oe);
    `CHK("status across pause", 8'h02, r)
    secp_spi_master_inst.frame(16, 32'h0500, 10, -1, r, oe);
    `CHK("status across data pause", 8'h02, r)
    send(8, 32'h04, r);
  endtask
  task automatic t_refuse;
    logic [7:0] r;
    logic oe;
    int b0;
    logic [7:0] bad [3] = '{8'h16, 8'h85, 8'h07};
    foreach (bad[i]) begin
      secp_spi_master_inst.frame(24, {8'h0, bad[i], 16'h0000}, -1, -1, r, oe);
      `CHK("so enable bad op", 1'b0, oe)
    end
    secp_spi_master_inst.frame(32, 32'h03123400, -1, -1, r, oe);
    `CHK("so enable array read", 1'b0, oe)
    b0 = busy_len;
    send(16, 32'h018c, r);
    rd_status(8'h05, r);
    `CHK("status write without latch", 9'h000, {r, 1'(busy_len != b0)})
  endtask
  task automatic t_status_write;
    logic [7:0] r;
    int b0;
    send(8, 32'h06, r);
    b0 = busy_len;
    send(16, 32'h01fe, r);
    repeat (4) @(posedge clk);
    rd_status(8'h05, r);
    `CHK("status while writing", 8'hff, r)
    send(8, 32'h06, r);
    for (int k = 0; k < WCYC + 40 && busy !== 1'b0; k++) @(posedge clk);
    @(posedge clk);
    `CHK("write cycle length", WCYC, busy_len - b0)
    rd_status(8'h05, r);
    `CHK("status after write", 8'h8c, r)
  endtask
  task automatic t_guard;
    logic [7:0] r;
    secp_spi_master_inst.wp_n_out = 1'b0;
    do_write(16, 32'h0100, -1, 1'b0);
    rd_status(8'h05, r);
    `CHK("guarded status", 8'h8c, r)
    secp_spi_master_inst.wp_n_out = 1'b1;
    do_write(16, 32'h0100, 10, 1'b0);
    rd_status(8'h05, r);
    `CHK("guard fall in frame", 8'h8c, r)
    secp_spi_master_inst.wp_n_out = 1'b1;
    do_write(16, 32'h0100, -1, 1'b1);
    secp_spi_master_inst.wp_n_out = 1'b0;
  endtask
  task automatic t_blocks;
    logic [7:0]  st [4] = '{8'h04, 8'h08, 8'h0c, 8'h00};
    logic [15:0] a0 [4] = '{16'hbfff, 16'h7fff, 16'h0000, 16'hffff};
    logic [15:0] a1 [4] = '{16'hc000, 16'h8000, 16'hffff, 16'h0000};
    logic [7:0]  r;
    foreach (st[i]) begin
      do_write(16, {16'h0000, 8'h01, st[i]}, -1, 1'b1);
      rd_status(8'h05, r);
      `CHK("block level", st[i], r)
      do_write(32, {8'h02, a0[i], 8'h5a}, -1, i != 2);
      do_write(32, {8'h02, a1[i], 8'ha5}, -1, i == 3);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    summarize;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_power_up;
    t_decode;
    t_refuse;
    t_status_write;
    t_guard;
    t_blocks;
    summarize;
  end
endmodule
